// ==== flp_pkg.sv ====
// Shared constants, carriers and helpers of the four-level interrupt prioritizer
package flp_pkg;

   // Number of request sources
   localparam int NUM_SRC = 7;
   // Number of sticky event bits in the status register
   localparam int NUM_EV = 3;

   // Register indexes; byte address is four times the index
   localparam logic [7:0] IDX_ENABLE = 8'hA8;
   localparam logic [7:0] IDX_PRIO_HI = 8'hB7;
   localparam logic [7:0] IDX_PRIO_LO = 8'hB8;
   localparam logic [7:0] IDX_STATUS = 8'hC0;
   localparam logic [7:0] IDX_MASK = 8'hC1;
   localparam logic [7:0] IDX_SERVICE = 8'hC2;

   // Reset values
   localparam logic [7:0] RST_ENABLE = 8'h00;
   localparam logic [6:0] RST_PRIO = 7'h00;
   localparam logic [2:0] RST_EVENTS = 3'h0;

   // Source bit positions, shared by enable and both priority registers
   localparam logic [2:0] BIT_EXT0 = 3'h0;
   localparam logic [2:0] BIT_TIMER0 = 3'h1;
   localparam logic [2:0] BIT_EXT1 = 3'h2;
   localparam logic [2:0] BIT_TIMER1 = 3'h3;
   localparam logic [2:0] BIT_UART = 3'h4;
   localparam logic [2:0] BIT_TIMER2 = 3'h5;
   localparam logic [2:0] BIT_ARRAY = 3'h6;
   localparam logic [2:0] BIT_GATE = 3'h7;

   // Polling order among equal levels, first entry wins
   localparam logic [2:0] POLL_ORDER [NUM_SRC] = '{BIT_EXT0, BIT_TIMER0, BIT_EXT1,
      BIT_TIMER1, BIT_ARRAY, BIT_UART, BIT_TIMER2};

   // Vector address per source bit position
   localparam logic [7:0] VECTOR_OF [NUM_SRC] = '{8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23,
      8'h2B, 8'h33};

   // Status event bits
   localparam int EV_VECTORED = 0;
   localparam int EV_PREEMPT = 1;
   localparam int EV_STRAY = 2;

   // Hardware flag clear strobes
   localparam int CLR_EXT0 = 0;
   localparam int CLR_TIMER0 = 1;
   localparam int CLR_EXT1 = 2;
   localparam int CLR_TIMER1 = 3;

   // Bus response
   localparam logic HRESP_OKAY = 1'b0;

   // AHB-Lite slave inputs
   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } flp_ahb_in_type;

   // AHB-Lite slave outputs
   typedef struct packed {
      logic hreadyout;
      logic hresp;
      logic [31:0] hrdata;
   } flp_ahb_out_type;

   // Core handshake towards the prioritizer
   typedef struct packed {
      logic ack;
      logic reti;
   } flp_cpu_in_type;

   // Request towards the core
   typedef struct packed {
      logic irq_valid;
      logic [7:0] vector;
   } flp_cpu_out_type;

   // Whole state of the prioritizer
   typedef struct packed {
      logic [7:0] enable;
      logic [6:0] prio_lo;
      logic [6:0] prio_hi;
      logic [3:0] isr;
      logic [2:0] status;
      logic [2:0] mask;
      logic irq;
      logic valid;
      logic [7:0] vector;
      logic [2:0] win_src;
      logic [1:0] win_lvl;
      logic [3:0] clear;
      logic wr_pend;
      logic [7:0] wr_idx;
      logic hreadyout;
      logic [31:0] hrdata;
   } flp_state_type;

   // Level of one source from its upper and lower priority bits
   function automatic logic [1:0] flp_level(input logic [6:0] hi, input logic [6:0] lo,
                                            input logic [2:0] b);
      flp_level = {hi[b], lo[b]};
   endfunction

   // Highest level in service: bit 2 says any, bits 1:0 the level
   function automatic logic [2:0] flp_top(input logic [3:0] isr);
      flp_top = 3'h0;
      for (int l = 0; l < 4; l++) begin
         if (isr[l]) begin
            flp_top = {1'b1, 2'(l)};
         end
      end
   endfunction

endpackage

// ==== flp_prioritizer.sv ====
// Four-level interrupt prioritizer with AHB-Lite register access
//
// Behaviour
// RULE1 - Seven sources, each given one of four levels
// RULE2 - Level is upper bit then lower bit
// RULE3 - Upper priority register sits at B7H
// RULE4 - Vector only if no equal/higher in service
// RULE5 - Blocked request waits until handler returns
// RULE6 - Higher level preempts the running handler
// RULE7 - Return resumes the interrupted lower handler
// RULE8 - Equal levels resolved by fixed polling order
// RULE9 - Hardware clears timer0/1 and edge external flags
// RULE10 - Enable register holds one bit per source
// RULE11 - Bit 7 of enable gates all sources
// RULE12 - Priority registers share enable bit layout
`timescale 1ns/1ns
module flp_prioritizer (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // Register bus
   input wire flp_pkg::flp_ahb_in_type i_ahb,
   output flp_pkg::flp_ahb_out_type o_ahb,
   // Peripheral request flags, one per source bit position
   input wire logic [6:0] i_req,
   // External request mode, high when transition triggered
   input wire logic [1:0] i_ext_edge,
   // Processor core handshake
   input wire flp_pkg::flp_cpu_in_type i_cpu,
   output flp_pkg::flp_cpu_out_type o_cpu,
   // One-cycle flag clear strobes to the peripherals
   output logic [3:0] o_flag_clear,
   // Event interrupt
   output logic o_irq
);
   import flp_pkg::*;

   flp_state_type st; // Registered state
   flp_state_type next_st; // Next state
   logic [6:0] elig; // Sources that may be vectored now
   logic [2:0] top; // Highest level in service
   logic found; // A winner exists
   logic [2:0] best_src; // Winning source bit
   logic [1:0] best_lvl; // Winning level
   logic addr_sel; // Address phase taken this cycle
   logic [7:0] addr_idx; // Decoded register index
   logic take_ack; // Core accepts the offered vector
   logic [2:0] ev_set; // Events raised this cycle
   logic [2:0] ev_clr; // Status bits cleared by software

   // Register read mux; unmapped indexes read as zero
   function automatic logic [31:0] read_reg(input flp_state_type s, input logic [7:0] idx,
                                            input logic [6:0] req);
      read_reg = 32'h0000_0000;
      case (idx)
         IDX_ENABLE: read_reg = {24'h00_0000, s.enable};
         IDX_PRIO_HI: read_reg = {25'h000_0000, s.prio_hi}; // [RULE3]
         IDX_PRIO_LO: read_reg = {25'h000_0000, s.prio_lo}; // [RULE12]
         IDX_STATUS: read_reg = {29'h0000_0000, s.status};
         IDX_MASK: read_reg = {29'h0000_0000, s.mask};
         IDX_SERVICE: read_reg = {17'h0_0000, req, 4'h0, s.isr};
         default: read_reg = 32'h0000_0000;
      endcase
   endfunction

   // Arbitration, bus decode and state update
   always_comb begin
      next_st = st;
      top = flp_top(st.isr);
      // Eligibility: own enable, global gate, and level above the one in service
      for (int b = 0; b < NUM_SRC; b++) begin
         elig[b] = i_req[b] && st.enable[b] && st.enable[BIT_GATE] // [RULE10] [RULE11]
                   && (!top[2] // [RULE4] [RULE5]
                   || flp_level(st.prio_hi, st.prio_lo, 3'(b)) > top[1:0]); // [RULE6]
      end
      // Walk in polling order; strict compare keeps the earlier source on a tie
      found = 1'b0;
      best_src = 3'h0;
      best_lvl = 2'h0;
      for (int k = 0; k < NUM_SRC; k++) begin
         if (elig[POLL_ORDER[k]] &&
             (!found || flp_level(st.prio_hi, st.prio_lo, POLL_ORDER[k]) > best_lvl)) begin
            found = 1'b1;
            best_src = POLL_ORDER[k]; // [RULE8]
            best_lvl = flp_level(st.prio_hi, st.prio_lo, POLL_ORDER[k]); // [RULE1] [RULE2]
         end
      end
      take_ack = i_cpu.ack && st.valid;
      // Offer the winner; withdrawn for one cycle after an accept so one
      // offer is never taken twice while the in-service set updates
      next_st.valid = found && !take_ack;
      next_st.win_src = best_src;
      next_st.win_lvl = best_lvl;
      next_st.vector = found ? VECTOR_OF[best_src] : 8'h00; // [RULE8]
      // Nesting: a return retires the highest level, an accept adds its level
      if (i_cpu.reti && top[2]) begin
         next_st.isr[top[1:0]] = 1'b0; // [RULE7]
      end
      if (take_ack) begin
         next_st.isr[st.win_lvl] = 1'b1; // [RULE6]
      end
      // Hardware clear of flags; level-triggered and other flags left to software
      next_st.clear = 4'h0;
      if (take_ack) begin
         next_st.clear[CLR_EXT0] = (st.win_src == BIT_EXT0) && i_ext_edge[0]; // [RULE9]
         next_st.clear[CLR_TIMER0] = (st.win_src == BIT_TIMER0); // [RULE9]
         next_st.clear[CLR_EXT1] = (st.win_src == BIT_EXT1) && i_ext_edge[1]; // [RULE9]
         next_st.clear[CLR_TIMER1] = (st.win_src == BIT_TIMER1); // [RULE9]
      end
      // Events for the status register
      ev_set = 3'h0;
      ev_set[EV_VECTORED] = take_ack;
      ev_set[EV_PREEMPT] = take_ack && top[2];
      ev_set[EV_STRAY] = i_cpu.reti && !top[2];
      // Address phase; only word-aligned low addresses map
      addr_sel = i_ahb.hsel && i_ahb.hready && i_ahb.htrans[1];
      addr_idx = (i_ahb.haddr[31:10] == 22'h00_0000 && i_ahb.haddr[1:0] == 2'h0)
                 ? i_ahb.haddr[9:2] : 8'hFF;
      next_st.wr_pend = addr_sel && i_ahb.hwrite;
      next_st.wr_idx = addr_idx;
      next_st.hreadyout = 1'b1;
      // Read data prepared one cycle ahead so it stands in the data phase
      next_st.hrdata = (addr_sel && !i_ahb.hwrite) ? read_reg(st, addr_idx, i_req)
                       : 32'h0000_0000;
      // Data phase write
      ev_clr = 3'h0;
      if (st.wr_pend) begin
         case (st.wr_idx)
            IDX_ENABLE: next_st.enable = i_ahb.hwdata[7:0]; // [RULE10] [RULE11]
            IDX_PRIO_HI: next_st.prio_hi = i_ahb.hwdata[6:0]; // [RULE3] [RULE12]
            IDX_PRIO_LO: next_st.prio_lo = i_ahb.hwdata[6:0]; // [RULE12]
            IDX_STATUS: ev_clr = i_ahb.hwdata[2:0];
            IDX_MASK: next_st.mask = i_ahb.hwdata[2:0];
            default: ev_clr = 3'h0; // Unmapped writes are dropped
         endcase
      end
      // Set wins over a write-one clear in the same cycle
      next_st.status = (st.status & ~ev_clr) | ev_set;
      next_st.irq = |(next_st.status & next_st.mask);
   end

   // State register
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st.enable <= RST_ENABLE;
         st.prio_lo <= RST_PRIO;
         st.prio_hi <= RST_PRIO;
         st.isr <= 4'h0;
         st.status <= RST_EVENTS;
         st.mask <= RST_EVENTS;
         st.irq <= 1'b0;
         st.valid <= 1'b0;
         st.vector <= 8'h00;
         st.win_src <= 3'h0;
         st.win_lvl <= 2'h0;
         st.clear <= 4'h0;
         st.wr_pend <= 1'b0;
         st.wr_idx <= 8'h00;
         st.hreadyout <= 1'b1;
         st.hrdata <= 32'h0000_0000;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state register, except hresp which is tied to OKAY
   assign o_ahb.hreadyout = st.hreadyout;
   assign o_ahb.hresp = HRESP_OKAY;
   assign o_ahb.hrdata = st.hrdata;
   assign o_cpu.irq_valid = st.valid;
   assign o_cpu.vector = st.vector;
   assign o_flag_clear = st.clear;
   assign o_irq = st.irq;

   // Checks on the prioritizer
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_b);

   // Global gate low means nothing is offered next cycle
   chk_gate_blocks_all: assert property ( // [RULE11]
      !st.enable[BIT_GATE] |=> !st.valid)
      else $error("vector offered with global gate off");

   // Offered source had its own enable and request a cycle earlier; the
   // index is applied after the history so the source offered now is used
   chk_source_enable_bit: assert property ( // [RULE10]
      st.valid |-> |(($past(st.enable) >> st.win_src) & 8'h01)
         && |(($past(i_req) >> st.win_src) & 7'h01))
      else $error("vector offered for a disabled source");

   // Offered level is the one formed from the upper and lower bits
   chk_level_from_bits: assert property ( // [RULE2]
      st.valid |-> st.win_lvl == flp_level($past(st.prio_hi), $past(st.prio_lo), st.win_src))
      else $error("offered level does not match priority bits");

   // Nothing offered unless above the level in service
   chk_service_block: assert property ( // [RULE4]
      st.valid |-> !$past(top[2]) || st.win_lvl > $past(top[1:0]))
      else $error("vector offered at or below level in service");

   // Accept marks the new level in service
   chk_preempt_nest: assert property ( // [RULE6]
      (i_cpu.ack && st.valid) |=> st.isr[$past(st.win_lvl)] && !st.valid)
      else $error("accepted level not marked in service");

   // Return without accept retires exactly the top level
   chk_resume_lower: assert property ( // [RULE7]
      (i_cpu.reti && top[2] && !i_cpu.ack) |=>
         st.isr == ($past(st.isr) & ~(4'h1 << $past(top[1:0]))))
      else $error("return did not retire the top level");

   // Vector matches the offered source
   chk_poll_vector: assert property ( // [RULE8]
      st.valid |-> st.vector == VECTOR_OF[st.win_src])
      else $error("vector address mismatch");

   // Timer 0 accept pulses its flag clear for one cycle
   chk_timer_clear: assert property ( // [RULE9]
      (i_cpu.ack && st.valid && st.win_src == BIT_TIMER0) |=>
         o_flag_clear[CLR_TIMER0] ##1 !o_flag_clear[CLR_TIMER0])
      else $error("timer 0 flag not cleared on vectoring");

   // Level-triggered external flags are left for software
   chk_level_kept: assert property ( // [RULE9]
      (i_cpu.ack && st.valid && ((st.win_src == BIT_EXT0 && !i_ext_edge[0])
         || (st.win_src == BIT_EXT1 && !i_ext_edge[1]))) |=>
         !o_flag_clear[CLR_EXT0] && !o_flag_clear[CLR_EXT1])
      else $error("level-triggered flag cleared by hardware");

   // Upper priority write lands with bit 7 dropped
   chk_upper_write: assert property ( // [RULE3]
      (st.wr_pend && st.wr_idx == IDX_PRIO_HI) |=> st.prio_hi == $past(i_ahb.hwdata[6:0]))
      else $error("upper priority write lost");

   // Interrupt output follows unmasked status
   chk_irq_level: assert property (
      o_irq == |(st.status & st.mask))
      else $error("interrupt output out of step with status");

   // Two levels nested at once
   cov_nested_two: cover property (st.isr[0] && st.isr[1]);
   // Winner chosen while several sources were eligible
   cov_tie_break: cover property (st.valid && $countones($past(elig)) > 1);
   // Return resumes a lower handler
   cov_resume: cover property (i_cpu.reti && $countones(st.isr) == 2);
   // Status set and clear in the same cycle
   cov_set_clear: cover property (|(ev_set & ev_clr));

endmodule // flp_prioritizer

// ==== flp_core_model.sv ====
// Behavioural processor core and peripheral request flags facing the prioritizer
`timescale 1ns/1ns
module flp_core_model (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // Prioritizer side
   input wire flp_pkg::flp_cpu_out_type i_cpu,
   input wire logic [3:0] i_flag_clear,
   output flp_pkg::flp_cpu_in_type o_cpu,
   output logic [6:0] o_req,
   // Bench control
   input wire logic [6:0] i_set,
   input wire logic [6:0] i_sw_clr,
   input wire logic i_ack_en,
   input wire logic [3:0] i_ack_wait,
   input wire logic i_reti,
   output logic [7:0] o_last_vec
);
   import flp_pkg::*;
   logic ack; // Accept strobe, high for one cycle and dropped if the offer is withdrawn
   logic [3:0] wait_cnt; // Cycles the current offer has stood
   // Return pulse comes straight from the bench
   assign o_cpu = '{ack: ack, reti: i_reti};
   // Core: accepts an offer after a chosen delay, so slow and prompt answers both occur
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ack <= 1'b0;
         wait_cnt <= 4'h0;
         o_last_vec <= 8'h00;
      end else if (ack && i_cpu.irq_valid) begin
         // Taken at this edge: record the vector and release
         ack <= 1'b0;
         wait_cnt <= 4'h0;
         o_last_vec <= i_cpu.vector;
      end else if (i_cpu.irq_valid && i_ack_en) begin
         ack <= (wait_cnt == i_ack_wait);
         wait_cnt <= wait_cnt + 4'h1;
      end else begin
         // Offer withdrawn or accepting disabled: a real core would not keep accepting
         ack <= 1'b0;
         wait_cnt <= 4'h0;
      end
   end
   // Flags: set and cleared by the bench, first four also dropped by hardware strobes
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_req <= 7'h00;
      end else begin
         o_req <= (o_req | i_set) & ~i_sw_clr & ~{3'h0, i_flag_clear};
      end
   end
endmodule // flp_core_model

// ==== test_four_level_interrupt_prioritizer.sv ====
// Self-checking bench of the four-level interrupt prioritizer
`timescale 1ns/1ns
`define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin bad_count++; \
   $display("BAD %s expected %0h seen %0h", what, exp, got); end end
module test_four_level_interrupt_prioritizer;
   import flp_pkg::*;
   typedef struct {logic [7:0] en, hi, lo; logic [6:0] req; logic ok;
      logic [7:0] vec;} flp_row_type;
   logic clk, rst_b, ack_en, reti, irq;
   logic [1:0] ext_edge;
   logic [3:0] ack_wait, flag_clear;
   logic [6:0] set, sw_clr, req;
   logic [7:0] last_vec;
   logic [31:0] d;
   int bad_count, num_checks;
   flp_ahb_in_type ahb_m, ahb_in; // Master drive; bus view with hready joined
   flp_ahb_out_type ahb_out;
   flp_cpu_in_type cpu_in;
   flp_cpu_out_type cpu_out;
   // Ordinary cases: enable, upper, lower priority, requests, offer expected, vector
   flp_row_type rows [13] = '{'{8'h7F, 8'h00, 8'h00, 7'h01, 0, 8'h00},
      '{8'hFF, 8'h00, 8'h00, 7'h7F, 1, 8'h03}, '{8'hFE, 8'h00, 8'h00, 7'h7F, 1, 8'h0B},
      '{8'hFC, 8'h00, 8'h00, 7'h7F, 1, 8'h13}, '{8'hF8, 8'h00, 8'h00, 7'h7F, 1, 8'h1B},
      '{8'hF0, 8'h00, 8'h00, 7'h7F, 1, 8'h33}, '{8'hB0, 8'h00, 8'h00, 7'h7F, 1, 8'h23},
      '{8'hA0, 8'h00, 8'h00, 7'h7F, 1, 8'h2B}, '{8'hFF, 8'h80, 8'h20, 7'h7F, 1, 8'h2B},
      '{8'hFF, 8'h10, 8'h20, 7'h7F, 1, 8'h23}, '{8'hFF, 8'h40, 8'h11, 7'h7F, 1, 8'h33},
      '{8'hFF, 8'h02, 8'h03, 7'h7F, 1, 8'h0B}, '{8'h81, 8'h00, 8'h00, 7'h7E, 0, 8'h00}};
   // Single bus master, so hready is the slave's own hreadyout
   always_comb begin
      ahb_in = ahb_m;
      ahb_in.hready = ahb_out.hreadyout;
   end
   flp_prioritizer i_dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_ahb(ahb_in), .o_ahb(ahb_out),
      .i_req(req), .i_ext_edge(ext_edge), .i_cpu(cpu_in), .o_cpu(cpu_out),
      .o_flag_clear(flag_clear), .o_irq(irq));
   flp_core_model i_core (.i_core_clk(clk), .i_rst_b(rst_b), .i_cpu(cpu_out),
      .i_flag_clear(flag_clear), .o_cpu(cpu_in), .o_req(req), .i_set(set), .i_sw_clr(sw_clr),
      .i_ack_en(ack_en), .i_ack_wait(ack_wait), .i_reti(reti), .o_last_vec(last_vec));
   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // One single word transfer; read data is taken at the end of the data phase
   task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge clk);
      ahb_m.hsel <= 1'b1;
      ahb_m.haddr <= {22'h0, idx, 2'h0};
      ahb_m.htrans <= 2'h2;
      ahb_m.hwrite <= w;
      do @(posedge clk); while (ahb_out.hreadyout !== 1'b1);
      ahb_m.htrans <= 2'h0;
      ahb_m.hwdata <= wd;
      do @(posedge clk); while (ahb_out.hreadyout !== 1'b1);
      rd = ahb_out.hrdata;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
      logic [31:0] x;
      bus(1'b1, idx, wd, x);
   endtask
   task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] x;
      bus(1'b0, idx, 32'h0, x);
      `CHK(nm, exp, x)
   endtask
   task automatic pulse_req(input logic [6:0] b);
      @(posedge clk);
      set <= b;
      @(posedge clk);
      set <= 7'h00;
   endtask
   task automatic do_reti();
      @(posedge clk);
      reti <= 1'b1;
      @(posedge clk);
      reti <= 1'b0;
   endtask
   // Bounded wait for the core to record a vector, then compare
   task automatic wait_vec(input logic [7:0] exp);
      for (int i = 0; i < 40 && last_vec !== exp; i++) @(posedge clk);
      `CHK("accepted vector", exp, last_vec)
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Watchdog, well beyond the few hundred cycles the tests need
   initial begin
      cyc(20000);
      bad_count++;
      report_and_stop();
   end
   initial begin
      rst_b = 1'b0;
      ahb_m = '0;
      ahb_m.hsize = 3'h2;
      set = 7'h00;
      sw_clr = 7'h00;
      ack_en = 1'b0;
      ack_wait = 4'h0;
      reti = 1'b0;
      ext_edge = 2'h3;
      cyc(20);
      rst_b <= 1'b1;
      // Reset values, and an unmapped word that must ignore writes
      rd_chk("enable", IDX_ENABLE, 32'h0);
      rd_chk("upper prio", IDX_PRIO_HI, 32'h0);
      rd_chk("lower prio", IDX_PRIO_LO, 32'h0);
      rd_chk("status", IDX_STATUS, 32'h0);
      wr(8'hA9, 32'hFF);
      rd_chk("unmapped", 8'hA9, 32'h0);
      $display("test reset done");
      // Table: gate, per-source enables, levels and polling order, no acceptance
      foreach (rows[i]) begin
         wr(IDX_ENABLE, {24'h0, rows[i].en});
         wr(IDX_PRIO_HI, {24'h0, rows[i].hi});
         wr(IDX_PRIO_LO, {24'h0, rows[i].lo});
         pulse_req(rows[i].req);
         cyc(3);
         `CHK("offer", rows[i].ok, cpu_out.irq_valid)
         `CHK("offered vector", rows[i].vec, cpu_out.vector)
         rd_chk("upper readback", IDX_PRIO_HI, {25'h0, rows[i].hi[6:0]});
         @(posedge clk);
         sw_clr <= 7'h7F;
         @(posedge clk);
         sw_clr <= 7'h00;
         cyc(2);
         $display("test row %0d done", i);
      end
      // Nesting: ext0 at level 0 served, t1 at level 0 waits, t0 at level 1 preempts
      wr(IDX_ENABLE, 32'hFF);
      wr(IDX_PRIO_HI, 32'h0);
      wr(IDX_PRIO_LO, 32'h02);
      wr(IDX_MASK, 32'h3);
      ack_en <= 1'b1;
      pulse_req(7'h01);
      wait_vec(8'h03);
      cyc(3);
      `CHK("ext0 flag", 1'b0, req[0])
      pulse_req(7'h08);
      cyc(6);
      `CHK("blocked vector", 8'h03, last_vec)
      pulse_req(7'h02);
      wait_vec(8'h0B);
      cyc(3);
      `CHK("timer0 flag", 1'b0, req[1])
      bus(1'b0, IDX_SERVICE, 32'h0, d);
      `CHK("in service", 4'h3, d[3:0])
      rd_chk("status", IDX_STATUS, 32'h3);
      `CHK("irq", 1'b1, irq)
      do_reti();
      cyc(4);
      `CHK("still blocked", 8'h0B, last_vec)
      bus(1'b0, IDX_SERVICE, 32'h0, d);
      `CHK("resumed", 4'h1, d[3:0])
      do_reti();
      wait_vec(8'h1B);
      do_reti();
      $display("test nesting done");
      // Interrupt: clear by writing ones, stray return, masking
      wr(IDX_STATUS, 32'h7);
      cyc(2);
      `CHK("irq cleared", 1'b0, irq)
      do_reti();
      cyc(2);
      `CHK("irq masked", 1'b0, irq)
      rd_chk("stray status", IDX_STATUS, 32'h4);
      wr(IDX_MASK, 32'h7);
      cyc(2);
      `CHK("irq unmasked", 1'b1, irq)
      wr(IDX_STATUS, 32'h4);
      cyc(2);
      `CHK("irq dropped", 1'b0, irq)
      $display("test interrupt done");
      // Level mode ext1 with a slow core: flag must survive vectoring
      ext_edge <= 2'h0;
      ack_wait <= 4'h5;
      wr(IDX_ENABLE, 32'h84);
      pulse_req(7'h04);
      wait_vec(8'h13);
      cyc(3);
      `CHK("level flag kept", 1'b1, req[2])
      @(posedge clk);
      sw_clr <= 7'h04;
      @(posedge clk);
      sw_clr <= 7'h00;
      do_reti();
      $display("test level mode done");
      report_and_stop();
   end
endmodule // test_four_level_interrupt_prioritizer
